// *** src/dss_pkg.sv ***
/*
  Constants, types and helper functions for the drum search and transfer
  sequencer. Assumes a single 100 MHz clock domain and that every user of
  these names refers to them as dss_pkg::name.
*/
// What this block does
// - buffer word: low half first, high half last
// - continuous write fills drum until buffer or drum ends
// - continuous read fills buffer until full or file end
// - locate compares words, reports matching drum address
// - search read starts reading at the matching word
// - bounded find stops at end-of-block, reports find address
// - all-ones word ends block; report following word
// - bounded find-and-fetch reads block from matching word
// - bounded find-and-fetch reports overflow address at end-of-block
// - bounded fetch reads to end-of-block, returns buffer word
// - locate operations need no buffer word
// - status code sits in result bits 0 to 5
// - count in upper 15 bits, address upper 23
// - codes 02, 03, 04 for search and fill endings
// - bad operation or inverted buffer word gives code 16
package dss_pkg;

  // ==========================================================
  // widths
  localparam int WORD_W  = 30;
  localparam int MADDR_W = 15;
  localparam int DADDR_W = 23;
  localparam int CODE_W  = 6;
  localparam int CNT_W   = 15;
  localparam int OP_W    = 3;
  localparam int RADDR_W = 4;
  localparam int RDATA_W = 32;

  // ==========================================================
  // result word layout
  localparam int RES_CNT_LSB  = 15;
  localparam int RES_ADDR_LSB = 7;

  // ==========================================================
  // status codes in hex; bad parameter 0E is octal 16
  localparam logic [CODE_W-1:0] CODE_OK         = 6'h01;
  localparam logic [CODE_W-1:0] CODE_EOF_NOFIND = 6'h02;
  localparam logic [CODE_W-1:0] CODE_EOB_NOFIND = 6'h03;
  localparam logic [CODE_W-1:0] CODE_BUF_FULL   = 6'h04;
  localparam logic [CODE_W-1:0] CODE_EOF_SHORT  = 6'h05;
  localparam logic [CODE_W-1:0] CODE_BAD_PARAM  = 6'h0E;

  // ==========================================================
  // operation codes
  typedef enum logic [OP_W-1:0] {
    OP_CONT_WRITE                = 3'h0,
    OP_CONT_READ                 = 3'h1,
    OP_LOCATE                    = 3'h2,
    OP_SEARCH_READ               = 3'h3,
    OP_BOUNDED_FIND_OP           = 3'h4,
    OP_BOUNDED_FIND_AND_FETCH_OP = 3'h5,
    OP_BOUNDED_FETCH_OP          = 3'h6,
    OP_ILLEGAL                   = 3'h7
  } dss_op_type;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [RADDR_W-1:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [RADDR_W-1:0] REG_IRQ_MASK   = 4'h4;
  localparam logic [RADDR_W-1:0] REG_DRUM_LAST  = 4'h8;
  localparam logic [RADDR_W-1:0] REG_RESULT     = 4'hC;
  localparam int IRQ_W        = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam logic [DADDR_W-1:0] DRUM_LAST_RST = 23'h7FFFFF;
  localparam logic [WORD_W-1:0]  EOB_WORD      = 30'h3FFFFFFF;

  // ==========================================================
  // carriers
  typedef struct packed {
    dss_op_type         op;
    logic [WORD_W-1:0]  bcw;
    logic [DADDR_W-1:0] drum_addr;
    logic [WORD_W-1:0]  ident;
  } dss_req_type;

  typedef struct packed {
    logic [MADDR_W-1:0] last;
    logic [MADDR_W-1:0] first;
  } dss_bcw_type;

  // ==========================================================
  // operation decoding
  function automatic logic op_searches(input dss_op_type op);
    return op == OP_LOCATE || op == OP_SEARCH_READ ||
           op == OP_BOUNDED_FIND_OP || op == OP_BOUNDED_FIND_AND_FETCH_OP;
  endfunction

  function automatic logic op_bounded(input dss_op_type op);
    return op == OP_BOUNDED_FIND_OP || op == OP_BOUNDED_FIND_AND_FETCH_OP ||
           op == OP_BOUNDED_FETCH_OP;
  endfunction

  function automatic logic op_moves_data(input dss_op_type op);
    return op != OP_LOCATE && op != OP_BOUNDED_FIND_OP;
  endfunction

  // result word builders
  function automatic logic [WORD_W-1:0] res_addr(input logic [CODE_W-1:0]  code,
                                                   input logic [DADDR_W-1:0] addr);
    return {addr, {(RES_ADDR_LSB-CODE_W){1'b0}}, code};
  endfunction

  function automatic logic [WORD_W-1:0] res_count(input logic [CODE_W-1:0] code,
                                                    input logic [CNT_W-1:0]  cnt);
    return {cnt, {(RES_CNT_LSB-CODE_W){1'b0}}, code};
  endfunction

endpackage

// *** src/dss_word_cmp.sv ***
/*
  Drum word classifier: exact identifier match and end-of-block detection.
  Purely combinational; assumes the word is stable for the cycle it is used.
*/
module dss_word_cmp (
  input  wire logic [dss_pkg::WORD_W-1:0] word,
  input  wire logic [dss_pkg::WORD_W-1:0] ident,
  output wire logic                       match,
  output wire logic                       eob
);

  // ==========================================================
  // classification
  assign match = (word == ident);
  assign eob   = (word == dss_pkg::EOB_WORD);

endmodule

// *** src/dss_sequencer.sv ***
/*
  Drum search and transfer sequencer: takes one request, walks the drum
  word by word, moves data to or from the memory buffer and hands back a
  result word. Assumes drum and memory reads answer in the following cycle
  and writes complete in the cycle of the strobe.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
module dss_sequencer (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // request side
  input  wire logic                          req_valid,
  input  wire dss_pkg::dss_req_type          req,
  output wire logic                          busy,
  output wire logic                          done,
  output      logic [dss_pkg::WORD_W-1:0]    result,
  output wire logic                          bcw_wr,
  output wire logic [dss_pkg::WORD_W-1:0]    bcw_out,
  // memory buffer side
  output wire logic                          mem_rd,
  output wire logic                          mem_wr,
  output wire logic [dss_pkg::MADDR_W-1:0]   mem_addr,
  output wire logic [dss_pkg::WORD_W-1:0]    mem_wdata,
  input  wire logic [dss_pkg::WORD_W-1:0]    mem_rdata,
  // drum side
  output wire logic                          drum_rd,
  output wire logic                          drum_wr,
  output wire logic [dss_pkg::DADDR_W-1:0]   drum_addr,
  output wire logic [dss_pkg::WORD_W-1:0]    drum_wdata,
  input  wire logic [dss_pkg::WORD_W-1:0]    drum_rdata,
  // register port
  input  wire logic [dss_pkg::RADDR_W-1:0]   reg_addr,
  input  wire logic [dss_pkg::RDATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output      logic [dss_pkg::RDATA_W-1:0]   reg_rdata,
  output wire logic                          irq
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_CHECK = 4'h1,
    ST_DRD   = 4'h2,
    ST_DCHK  = 4'h3,
    ST_MWR   = 4'h4,
    ST_MRD   = 4'h5,
    ST_MLAT  = 4'h6,
    ST_DWR   = 4'h7,
    ST_BCW   = 4'h8,
    ST_OVF   = 4'h9,
    ST_OCHK  = 4'hA,
    ST_FIN   = 4'hB
  } dss_state_type;

  dss_state_type                state_ff,   nxt_state;
  dss_pkg::dss_op_type          op_ff;
  logic [dss_pkg::WORD_W-1:0]   ident_ff;
  logic [dss_pkg::MADDR_W-1:0]  last_ff;
  logic [dss_pkg::MADDR_W-1:0]  mptr_ff,    nxt_mptr;
  logic [dss_pkg::DADDR_W:0]    dptr_ff,    nxt_dptr;
  logic [dss_pkg::CNT_W-1:0]    cnt_ff,     nxt_cnt;
  logic [dss_pkg::WORD_W-1:0]   data_ff,    nxt_data;
  logic [dss_pkg::WORD_W-1:0]   result_ff,  nxt_result;
  logic                         xfer_ff,    nxt_xfer;
  logic [dss_pkg::DADDR_W-1:0]  dlast_ff;
  logic [dss_pkg::IRQ_W-1:0]    istat_ff;
  logic [dss_pkg::IRQ_W-1:0]    imask_ff;

  // ==========================================================
  // decoding
  dss_pkg::dss_bcw_type         req_bcw;
  wire logic                    at_eof;
  wire logic                    buf_last;
  wire logic                    word_match;
  wire logic                    word_eob;
  wire logic                    bounded;
  wire logic                    bad_req;
  wire logic [dss_pkg::CNT_W-1:0]   cnt_inc;
  wire logic [dss_pkg::DADDR_W:0]   dptr_inc;
  wire logic [dss_pkg::MADDR_W-1:0] mptr_inc;
  wire logic                    sel_stat;
  wire logic                    sel_mask;
  wire logic                    sel_last;
  wire logic                    sel_res;

  assign req_bcw  = req.bcw;
  assign at_eof   = dptr_ff > {1'b0, dlast_ff};
  assign buf_last = mptr_ff == last_ff;
  assign bounded  = dss_pkg::op_bounded(op_ff);
  assign cnt_inc  = cnt_ff + 15'h0001;
  assign dptr_inc = dptr_ff + 24'h000001;
  assign mptr_inc = mptr_ff + 15'h0001;
  // locate operations skip the buffer check entirely
  assign bad_req  = op_ff == dss_pkg::OP_ILLEGAL ||
                    (dss_pkg::op_moves_data(op_ff) && mptr_ff > last_ff);

  dss_word_cmp u_cmp (
    .word  (drum_rdata),
    .ident (ident_ff),
    .match (word_match),
    .eob   (word_eob)
  );

  // ==========================================================
  // port drive
  assign busy       = state_ff != ST_IDLE &&
                      state_ff != ST_FIN;
  assign done       = state_ff == ST_FIN;
  assign result     = result_ff;
  assign drum_rd    = state_ff == ST_DRD || state_ff == ST_OVF;
  assign drum_wr    = state_ff == ST_DWR;
  assign drum_addr  = dptr_ff[dss_pkg::DADDR_W-1:0];
  assign drum_wdata = data_ff;
  assign mem_rd     = state_ff == ST_MRD;
  assign mem_wr     = state_ff == ST_MWR;
  assign mem_addr   = mptr_ff;
  assign mem_wdata  = data_ff;
  assign bcw_wr     = state_ff == ST_BCW;
  assign bcw_out    = {last_ff, mptr_ff};

  // ==========================================================
  // sequencing
  always_comb begin
    nxt_state  = state_ff;
    nxt_mptr   = mptr_ff;
    nxt_dptr   = dptr_ff;
    nxt_cnt    = cnt_ff;
    nxt_data   = data_ff;
    nxt_result = result_ff;
    nxt_xfer   = xfer_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid) begin
          nxt_state = ST_CHECK;
          nxt_mptr  = req_bcw.first;
          nxt_dptr  = {1'b0, req.drum_addr};
          nxt_cnt   = '0;
          nxt_xfer  = !dss_pkg::op_searches(req.op);
        end
      end
      ST_CHECK: begin
        if (bad_req) begin
          nxt_result = dss_pkg::res_addr(dss_pkg::CODE_BAD_PARAM, '0);
          nxt_state  = ST_FIN;
        end else if (op_ff == dss_pkg::OP_CONT_WRITE) begin
          nxt_state = ST_MRD;
        end else begin
          nxt_state = ST_DRD;
        end
      end
      ST_DRD: begin
        if (at_eof) begin
          nxt_state = ST_FIN;
          if (xfer_ff)
            nxt_result = dss_pkg::res_count(dss_pkg::CODE_EOF_SHORT, cnt_ff);
          else
            nxt_result = dss_pkg::res_addr(dss_pkg::CODE_EOF_NOFIND, '0);
        end else begin
          nxt_state = ST_DCHK;
        end
      end
      ST_DCHK: begin
        nxt_data = drum_rdata;
        if (bounded && word_eob) begin
          // end-of-block: next word carries the overflow address
          nxt_dptr  = dptr_inc;
          nxt_state = xfer_ff ? ST_BCW : ST_OVF;
        end else if (!xfer_ff && !word_match) begin
          nxt_dptr  = dptr_inc;
          nxt_state = ST_DRD;
        end else if (!xfer_ff && !dss_pkg::op_moves_data(op_ff)) begin
          nxt_result = dss_pkg::res_addr(dss_pkg::CODE_OK,
                                         dptr_ff[dss_pkg::DADDR_W-1:0]);
          nxt_state  = ST_FIN;
        end else begin
          nxt_xfer  = 1'b1;
          nxt_state = ST_MWR;
        end
      end
      ST_MWR: begin
        nxt_cnt = cnt_inc;
        if (buf_last) begin
          nxt_state = ST_FIN;
          if (bounded)
            nxt_result = dss_pkg::res_addr(dss_pkg::CODE_BUF_FULL, '0);
          else
            nxt_result = dss_pkg::res_count(dss_pkg::CODE_OK, cnt_inc);
        end else begin
          nxt_mptr  = mptr_inc;
          nxt_dptr  = dptr_inc;
          nxt_state = ST_DRD;
        end
      end
      ST_MRD: begin
        if (at_eof) begin
          nxt_result = dss_pkg::res_count(dss_pkg::CODE_EOF_SHORT, cnt_ff);
          nxt_state  = ST_FIN;
        end else begin
          nxt_state = ST_MLAT;
        end
      end
      ST_MLAT: begin
        nxt_data  = mem_rdata;
        nxt_state = ST_DWR;
      end
      ST_DWR: begin
        nxt_cnt = cnt_inc;
        if (buf_last) begin
          nxt_result = dss_pkg::res_count(dss_pkg::CODE_OK, cnt_inc);
          nxt_state  = ST_FIN;
        end else begin
          nxt_mptr  = mptr_inc;
          nxt_dptr  = dptr_inc;
          nxt_state = ST_MRD;
        end
      end
      ST_BCW: begin
        nxt_state = ST_OVF;
      end
      ST_OVF: begin
        nxt_state = ST_OCHK;
      end
      ST_OCHK: begin
        nxt_state  = ST_FIN;
        nxt_result = dss_pkg::res_addr(xfer_ff ? dss_pkg::CODE_OK : dss_pkg::CODE_EOB_NOFIND,
                                       drum_rdata[dss_pkg::DADDR_W-1:0]);
      end
      ST_FIN: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      mptr_ff   <= '0;
      dptr_ff   <= '0;
      cnt_ff    <= '0;
      data_ff   <= '0;
      result_ff <= '0;
      xfer_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      mptr_ff   <= nxt_mptr;
      dptr_ff   <= nxt_dptr;
      cnt_ff    <= nxt_cnt;
      data_ff   <= nxt_data;
      result_ff <= nxt_result;
      xfer_ff   <= nxt_xfer;
    end
  end

  // request capture, only while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_ff    <= dss_pkg::OP_CONT_WRITE;
      ident_ff <= '0;
      last_ff  <= '0;
    end else if (state_ff == ST_IDLE && req_valid) begin
      op_ff    <= req.op;
      ident_ff <= req.ident;
      last_ff  <= req_bcw.last;
    end
  end

  // ==========================================================
  // register port and interrupt
  wire logic [dss_pkg::IRQ_W-1:0] irq_set;
  wire logic [dss_pkg::IRQ_W-1:0] irq_clr;
  wire logic                      is_err;

  assign sel_stat = reg_addr == dss_pkg::REG_IRQ_STATUS;
  assign sel_mask = reg_addr == dss_pkg::REG_IRQ_MASK;
  assign sel_last = reg_addr == dss_pkg::REG_DRUM_LAST;
  assign sel_res  = reg_addr == dss_pkg::REG_RESULT;
  assign is_err   = result_ff[dss_pkg::CODE_W-1:0] != dss_pkg::CODE_OK;
  assign irq_set  = {done && is_err, done};
  assign irq_clr  = (reg_wr && sel_stat) ? reg_wdata[dss_pkg::IRQ_W-1:0] : '0;
  assign irq      = |(istat_ff & imask_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_ff <= '0;
      imask_ff <= '0;
      dlast_ff <= dss_pkg::DRUM_LAST_RST;
    end else begin
      istat_ff <= (istat_ff & ~irq_clr) | irq_set;
      if (reg_wr && sel_mask)
        imask_ff <= reg_wdata[dss_pkg::IRQ_W-1:0];
      if (reg_wr && sel_last && !busy)
        dlast_ff <= reg_wdata[dss_pkg::DADDR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_rd) begin
      reg_rdata <= '0;
      if (sel_stat)
        reg_rdata <= {{(dss_pkg::RDATA_W-dss_pkg::IRQ_W){1'b0}}, istat_ff};
      if (sel_mask)
        reg_rdata <= {{(dss_pkg::RDATA_W-dss_pkg::IRQ_W){1'b0}}, imask_ff};
      if (sel_last)
        reg_rdata <= {{(dss_pkg::RDATA_W-dss_pkg::DADDR_W){1'b0}}, dlast_ff};
      if (sel_res)
        reg_rdata <= {{(dss_pkg::RDATA_W-dss_pkg::WORD_W){1'b0}}, result_ff};
    end else
      reg_rdata <= '0;
  end

endmodule

// *** tb/dss_properties.sv ***
/*
  Checker for the drum search and transfer sequencer, bound to its top module.
  Assumes one clock domain and the synchronous active-low reset.
*/
module dss_properties (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        req_valid,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic [dss_pkg::WORD_W-1:0]  result,
  input wire logic                        bcw_wr,
  input wire logic                        mem_rd,
  input wire logic                        mem_wr,
  input wire logic [dss_pkg::WORD_W-1:0]  mem_wdata,
  input wire logic [dss_pkg::WORD_W-1:0]  mem_rdata,
  input wire logic                        drum_rd,
  input wire logic                        drum_wr,
  input wire logic [dss_pkg::WORD_W-1:0]  drum_wdata,
  input wire logic [dss_pkg::WORD_W-1:0]  drum_rdata,
  input wire logic                        reg_rd,
  input wire logic [dss_pkg::RDATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // request handshake
  wire logic take = req_valid && !busy && !done;
  a_accept_busy: assert property (take |=> busy && !done)
    else $error("accepted request did not raise busy");
  a_done_single: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_done_after: assert property (done |-> $past(busy) && !busy)
    else $error("done without a busy phase");
  a_done_bound: assert property (take |-> ##[2:600] done)
    else $error("request never completed");
  // ==========================================================
  // result word
  a_code_legal: assert property (done |-> result[5:0] inside {6'h01, 6'h02, 6'h03,
                                 6'h04, 6'h05, 6'h0E})
    else $error("unknown status code");
  a_bad_upper: assert property (done && result[5:0] == 6'h0E |->
                                result[29:6] == 24'h0)
    else $error("bad parameter result carries data");
  a_fetch_ends: assert property (bcw_wr |-> ##[1:6] done)
    else $error("buffer word written back without completion");
  // ==========================================================
  // data paths
  a_drum_wr_data: assert property (drum_wr |-> drum_wdata == $past(mem_rdata) &&
                                   $past(mem_rd, 2))
    else $error("drum write data not the fetched buffer word");
  a_mem_wr_data: assert property (mem_wr |-> mem_wdata == $past(drum_rdata) &&
                                  $past(drum_rd, 2))
    else $error("buffer write data not the fetched drum word");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("register read data outside its cycle");
  c_fetch_end: cover property (bcw_wr);
  c_bad_param: cover property (done && result[5:0] == 6'h0E);
  c_eob: cover property (done && result[5:0] == 6'h03);
endmodule

bind dss_sequencer dss_properties u_props (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .busy(busy), .done(done),
  .result(result), .bcw_wr(bcw_wr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .drum_rd(drum_rd), .drum_wr(drum_wr),
  .drum_wdata(drum_wdata), .drum_rdata(drum_rdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// *** tb/dss_far_model.sv ***
/*
  Far-side model: a 64-word drum and a 64-word memory buffer.
  Assumes reads answer in the cycle after the strobe and writes land at once.
*/
module dss_far_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [14:0] mem_addr,
  input  wire logic [29:0] mem_wdata,
  output wire logic [29:0] mem_rdata,
  input  wire logic        drum_rd,
  input  wire logic        drum_wr,
  input  wire logic [22:0] drum_addr,
  input  wire logic [29:0] drum_wdata,
  output wire logic [29:0] drum_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] drum [64];
  logic [29:0] mem [64];
  logic [29:0] d_q = '0;
  logic [29:0] m_q = '0;
  logic        d_v = 1'b0;
  logic        m_v = 1'b0;
  // ==========================================================
  // storage and read answers
  always @(posedge clk) begin
    d_v <= drum_rd;
    m_v <= mem_rd;
    if (drum_rd) d_q <= drum[drum_addr[5:0]];
    if (mem_rd) m_q <= mem[mem_addr[5:0]];
    if (drum_wr) drum[drum_addr[5:0]] <= drum_wdata;
    if (mem_wr) mem[mem_addr[5:0]] <= mem_wdata;
  end
  // outside the answer cycle the lines show the inverted word
  assign drum_rdata = d_v ? d_q : ~d_q;
  assign mem_rdata  = m_v ? m_q : ~m_q;
endmodule

// *** tb/dss_sequencer_tb.sv ***
/*
  Self-checking bench for the drum search and transfer sequencer.
  Assumes the far-side model holds a 64-word drum and memory buffer.
*/
module dss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 req_valid = 1'b0;
  dss_pkg::dss_req_type req = '0;
  logic                 busy, done, bcw_wr, mem_rd, mem_wr, drum_rd, drum_wr, irq;
  logic [29:0]          result, bcw_out, mem_wdata, mem_rdata, drum_wdata, drum_rdata;
  logic [29:0]          bcw_seen = '0;
  logic [14:0]          mem_addr;
  logic [22:0]          drum_addr;
  logic [3:0]           reg_addr = '0;
  logic [31:0]          reg_wdata = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  int                   failures = 0;
  int                   n_checks = 0;
  always #5 clk = ~clk;

  dss_sequencer u_dut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .busy(busy),
    .done(done), .result(result), .bcw_wr(bcw_wr), .bcw_out(bcw_out), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .drum_rd(drum_rd), .drum_wr(drum_wr), .drum_addr(drum_addr), .drum_wdata(drum_wdata),
    .drum_rdata(drum_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );
  dss_far_model u_far (
    .clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .drum_rd(drum_rd), .drum_wr(drum_wr),
    .drum_addr(drum_addr), .drum_wdata(drum_wdata), .drum_rdata(drum_rdata)
  );
  // ==========================================================
  // shared tasks
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic res(input logic [31:0] e);
    chk("result", e, {2'h0, result});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic run(input dss_pkg::dss_op_type op, input logic [29:0] bcw,
                     input logic [22:0] da, input logic [29:0] id);
    int n = 0;
    @(posedge clk);
    req       <= {op, bcw, da, id};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
      if (bcw_wr === 1'b1) bcw_seen = bcw_out;
      n++;
      if (n > 1000) begin
        failures++;
        $display("BAD done expected 1 seen %b", done);
        end_sim;
      end
    end
  endtask
  function automatic logic [31:0] ea(input logic [22:0] a, input logic [5:0] c);
    return {2'h0, a, 1'h0, c};
  endfunction
  function automatic logic [31:0] ec(input logic [14:0] w, input logic [5:0] c);
    return {2'h0, w, 9'h000, c};
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 64; i++) u_far.drum[i] = 30'(i + 32'h100);
    u_far.drum[20] = 30'h3FFFFFFF;
    u_far.drum[21] = 30'h0012345;
    for (int i = 0; i < 3; i++) u_far.mem[40+i] = 30'(i + 32'hAAA0);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h8, 32'h007FFFFF, "drum_last");
    rd(4'h4, 32'h0, "mask");
    rd(4'hC, 32'h0, "result");
    wr(4'h3, 32'hFFFFFFFF);
    rd(4'h3, 32'h0, "unmapped");
    wr(4'h8, 32'h3F);
    rd(4'h8, 32'h3F, "drum_last");
    $display("test registers done");
    run(dss_pkg::OP_LOCATE, {15'h1, 15'h9}, 23'h2, 30'h105);
    res(ea(23'h5, 6'h01));
    chk("irq", 32'h0, {31'h0, irq});
    rd(4'h0, 32'h1, "irq_status");
    wr(4'h4, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h0, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    run(dss_pkg::OP_LOCATE, 30'h0, 23'h2, 30'h20000105);
    res(ec(15'h0, 6'h02));
    rd(4'h0, 32'h3, "irq_status");
    wr(4'h0, 32'h3);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test locate done");
    run(dss_pkg::OP_BOUNDED_FIND_OP, 30'h0, 23'hA, 30'h10C);
    res(ea(23'hC, 6'h01));
    run(dss_pkg::OP_BOUNDED_FIND_OP, 30'h0, 23'hF, 30'h3);
    res(ea(23'h12345, 6'h03));
    run(dss_pkg::OP_BOUNDED_FIND_AND_FETCH_OP, {15'h1E, 15'h1E}, 23'hF, 30'h3);
    res(ea(23'h12345, 6'h03));
    run(dss_pkg::OP_BOUNDED_FIND_AND_FETCH_OP, {15'h1E, 15'h1E}, 23'hF, 30'h112);
    res(ec(15'h0, 6'h04));
    chk("mem", 32'h112, {2'h0, u_far.mem[30]});
    run(dss_pkg::OP_BOUNDED_FETCH_OP, {15'h19, 15'h10}, 23'h11, 30'h0);
    res(ea(23'h12345, 6'h01));
    chk("bcw_out", {2'h0, 15'h19, 15'h13}, {2'h0, bcw_seen});
    for (int i = 0; i < 3; i++) chk("mem", 32'h111 + i, {2'h0, u_far.mem[16+i]});
    $display("test bounded done");
    run(dss_pkg::OP_CONT_READ, {15'hB, 15'h8}, 23'h1E, 30'h0);
    res(ec(15'h4, 6'h01));
    for (int i = 0; i < 4; i++) chk("mem", 32'h11E + i, {2'h0, u_far.mem[8+i]});
    run(dss_pkg::OP_CONT_WRITE, {15'h2A, 15'h28}, 23'h3C, 30'h0);
    res(ec(15'h3, 6'h01));
    for (int i = 0; i < 3; i++) chk("drum", 32'hAAA0 + i, {2'h0, u_far.drum[60+i]});
    run(dss_pkg::OP_CONT_WRITE, {15'h2D, 15'h28}, 23'h3E, 30'h0);
    res(ec(15'h2, 6'h05));
    chk("drum", 32'hAAA1, {2'h0, u_far.drum[63]});
    run(dss_pkg::OP_SEARCH_READ, {15'h1, 15'h0}, 23'h2D, 30'h132);
    res(ec(15'h2, 6'h01));
    chk("mem", 32'h132, {2'h0, u_far.mem[0]});
    chk("mem", 32'h133, {2'h0, u_far.mem[1]});
    $display("test transfer done");
    run(dss_pkg::OP_ILLEGAL, 30'h0, 23'h0, 30'h0);
    res(ec(15'h0, 6'h0E));
    run(dss_pkg::OP_CONT_READ, {15'h5, 15'h9}, 23'h0, 30'h0);
    res(ec(15'h0, 6'h0E));
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0E, "result");
    $display("test refusal done");
    end_sim;
  end
endmodule
